/* File: hw/sqf_pkg.sv */
package sqf_pkg;
// Function
// - End-of-queue frame done sets end-of-queue flag.
// - Flag set stops transfers, clears running status.
// - Clearing the flag resumes queued transfers.
// - Transmit FIFO accepts writes while stopped until full.
// - Transmit flush pulse empties the transmit FIFO.
// - Receive flush pulse empties the receive FIFO.
// - Clear-count command resets counter; direct write loads it.
// - Device starts new frames only while halt is clear.
// - Serial clock period is prescaler times scaler, halved by the double-rate bit and rounded down to even.
// - Link delays are delay prescaler times scaler.
// - Oldest-entry pointer and counter readable per FIFO.
// - Oldest transmit address is base plus four pointer.
// - Newest transmit address uses counter plus pointer minus one.
// - Oldest receive address is base plus four pointer.
// - Newest receive address uses counter plus pointer minus one.
// - Request only when enabled and flag from command.
// - Flag event at last bit of frame.

localparam int CMD_W = 32;
localparam int DATA_W = 16;
localparam int EOQ_POS = 27;
localparam int CLEAR_COUNT_BIT_POS = 26;
localparam int TCNT_W = 16;
localparam int TIME_W = 20;
localparam int ADDR_W = 32;
localparam int ENTRY_BYTES = 4;
localparam int FIFO_DEPTH = 4;
localparam int FRAME_BITS = 8;
localparam logic [ADDR_W-1:0] TX_FIFO_BASE = 32'h0000_003C;
localparam logic [ADDR_W-1:0] RX_FIFO_BASE = 32'h0000_007C;
localparam logic [TIME_W-1:0] TIME_ONE = 20'h0_0001;

typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_LEAD = 4'h2,
    ST_SHIFT = 4'h4,
    ST_TRAIL = 4'h8
} sqf_state_t;

// Prescaler codes give 2/3/5/7 for the baud rate and 1/3/5/7 for delays.
function automatic logic [TIME_W-1:0] sqf_prescale(input logic [1:0] code, input logic dly);
    case (code)
        2'h0: return dly ? 20'h0_0001 : 20'h0_0002;
        2'h1: return 20'h0_0003;
        2'h2: return 20'h0_0005;
        default: return 20'h0_0007;
    endcase
endfunction

// Baud scaler: 2, 4, 6, 8, then powers of two; delay scaler: 2 to 65536.
function automatic logic [TIME_W-1:0] sqf_scale(input logic [3:0] code, input logic dly);
    if (dly) begin
        return TIME_ONE << (5'(code) + 5'h01);
    end
    if (code < 4'h4) begin
        return TIME_W'((code + 4'h1) * 2);
    end
    return TIME_ONE << code;
endfunction

endpackage

/* File: hw/sqf_fifo_if.sv */
`timescale 1ns/1ps
interface sqf_fifo_if #(
    parameter int W = 32,
    parameter int DEPTH = 4
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    logic push;
    logic [W-1:0] push_data;
    logic pop;
    logic flush;
    logic full;
    logic empty;
    logic [W-1:0] head;
    logic [CW-1:0] count;
    logic [PW-1:0] ptr;
    modport owner (input push, push_data, pop, flush, output full, empty, head, count, ptr);
    modport user (output push, push_data, pop, flush, input full, empty, head, count, ptr);
endinterface

/* File: hw/sqf_timer.sv */
`timescale 1ns/1ps
module sqf_timer #(
    parameter int W = sqf_pkg::TIME_W
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic load,
    input wire logic [W-1:0] length,
    output logic done,
    output logic busy
);
    import sqf_pkg::*;

    logic [W-1:0] cnt;

    if (W < 2) begin : g_bad
        $error("sqf_timer: W too small");
    end

    // A load of length L makes done rise in the L-th cycle after it.
    always_ff @(posedge clock) begin
        if (srst) begin
            cnt <= '0;
        end else if (load) begin
            cnt <= length;
        end else if (cnt != '0) begin
            cnt <= cnt - 1'b1;
        end
    end

    assign done = cnt == W'(1);
    assign busy = cnt != '0;

    AST_TIMER_LEN: assert property (@(posedge clock) disable iff (srst)
        (load && length == W'(3)) ##1 (!load [*2]) |=> done)
        else $error("timer did not expire after three cycles");
    AST_TIMER_ONCE: assert property (@(posedge clock) disable iff (srst)
        done && !load |=> !busy)
        else $error("timer kept running after expiry");
endmodule

/* File: hw/sqf_fifo.sv */
`timescale 1ns/1ps
module sqf_fifo #(
    parameter int W = 32,
    parameter int DEPTH = 4,
    parameter logic [sqf_pkg::ADDR_W-1:0] BASE = '0
) (
    input wire logic clock,
    input wire logic srst,
    sqf_fifo_if.owner port,
    output logic [sqf_pkg::ADDR_W-1:0] first_addr,
    output logic [sqf_pkg::ADDR_W-1:0] last_addr
);
    import sqf_pkg::*;

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0] mem [DEPTH];
    logic [PW-1:0] ptr;
    logic [CW-1:0] count;

    if (DEPTH < 2) begin : g_bad
        $error("sqf_fifo: DEPTH must be at least 2");
    end

    // Flush wins over a push or pop in the same cycle.
    wire do_push = port.push & (count != CW'(DEPTH)) & ~port.flush;
    wire do_pop = port.pop & (count != '0) & ~port.flush;
    wire [PW-1:0] ptr_inc = (ptr == PW'(DEPTH - 1)) ? '0 : ptr + 1'b1;
    wire [PW-1:0] wr_idx = PW'((int'(ptr) + int'(count)) % DEPTH);
    wire [PW-1:0] last_idx = PW'((int'(ptr) + int'(count) + DEPTH - 1) % DEPTH);

    always_ff @(posedge clock) begin
        if (srst || port.flush) begin
            ptr <= '0;
            count <= '0;
        end else begin
            if (do_pop) begin
                ptr <= ptr_inc;
            end
            count <= count + CW'(do_push) - CW'(do_pop);
        end
    end

    always_ff @(posedge clock) begin
        if (do_push) begin
            mem[wr_idx] <= port.push_data;
        end
    end

    assign port.full = count == CW'(DEPTH);
    assign port.empty = count == '0;
    assign port.head = mem[ptr];
    assign port.count = count;
    assign port.ptr = ptr;
    assign first_addr = BASE + ADDR_W'(int'(ptr) * ENTRY_BYTES);
    assign last_addr = BASE + ADDR_W'(int'(last_idx) * ENTRY_BYTES);

    AST_FIFO_WRAP: assert property (@(posedge clock) disable iff (srst)
        do_pop && ptr == PW'(DEPTH - 1) |=> ptr == '0)
        else $error("pointer did not wrap to zero");
    AST_FIFO_FLUSH: assert property (@(posedge clock) disable iff (srst)
        port.flush |=> count == '0 && ptr == '0)
        else $error("flush left entries counted");
    AST_FIFO_COUNT: assert property (@(posedge clock) disable iff (srst)
        !port.flush && port.push && !port.pop && !port.full |=> count == $past(count) + 1'b1)
        else $error("push not counted");
endmodule

/* File: hw/sqf_top.sv */
`timescale 1ns/1ps
module sqf_top #(
    parameter int FIFO_DEPTH = sqf_pkg::FIFO_DEPTH,
    parameter int FRAME_BITS = sqf_pkg::FRAME_BITS,
    localparam int PW = $clog2(FIFO_DEPTH),
    localparam int CW = $clog2(FIFO_DEPTH + 1)
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic halt,
    input wire logic master_select_bit,
    input wire logic transmit_flush_bit,
    input wire logic receive_flush_bit,
    input wire logic end_of_queue_flag_clear,
    input wire logic end_of_queue_request_enable,
    input wire logic double_rate_bit,
    input wire logic [1:0] baud_prescaler,
    input wire logic [3:0] baud_scaler,
    input wire logic [1:0] delay_prescaler,
    input wire logic [3:0] delay_scaler,
    input wire logic tcnt_write,
    input wire logic [sqf_pkg::TCNT_W-1:0] tcnt_wdata,
    input wire logic tx_push_valid,
    input wire logic [sqf_pkg::CMD_W-1:0] tx_push_data,
    output logic tx_push_ready,
    input wire logic rx_pop,
    output logic [sqf_pkg::DATA_W-1:0] receive_pop_register,
    output logic end_of_queue_flag,
    output logic end_of_queue_request,
    output logic running_status_bit,
    output logic receive_drain_flag,
    output logic [PW-1:0] transmit_next_pointer,
    output logic [CW-1:0] transmit_entry_counter,
    output logic [PW-1:0] receive_pop_next_pointer,
    output logic [CW-1:0] receive_entry_counter,
    output logic [sqf_pkg::ADDR_W-1:0] tx_first_addr,
    output logic [sqf_pkg::ADDR_W-1:0] tx_last_addr,
    output logic [sqf_pkg::ADDR_W-1:0] rx_first_addr,
    output logic [sqf_pkg::ADDR_W-1:0] rx_last_addr,
    output logic [sqf_pkg::TCNT_W-1:0] transfer_counter_field,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic pcs_n_in,
    output logic pcs_n_out,
    output logic pcs_n_oe,
    input wire logic sin,
    output logic sout
);
    import sqf_pkg::*;

    localparam int BW = $clog2(DATA_W + 1);

    if (FIFO_DEPTH < 2 || FRAME_BITS < 2 || FRAME_BITS > DATA_W) begin : g_bad
        $error("sqf_top: FIFO_DEPTH or FRAME_BITS out of range");
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // The first stage of each chain feeds only the second stage.
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic pcs_s1;
    logic pcs_s2;
    logic sin_s1;
    logic sin_s2;

    always_ff @(posedge clock) begin
        if (srst) begin
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_s3 <= 1'b0;
            pcs_s1 <= 1'b1;
            pcs_s2 <= 1'b1;
            sin_s1 <= 1'b0;
            sin_s2 <= 1'b0;
        end else begin
            sck_s1 <= sck_in;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
            pcs_s1 <= pcs_n_in;
            pcs_s2 <= pcs_s1;
            sin_s1 <= sin;
            sin_s2 <= sin_s1;
        end
    end

    wire sck_rise = sck_s2 & ~sck_s3;
    wire sck_fall = ~sck_s2 & sck_s3;

    // ----------------------------------------------------------------
    // FIFOs
    // ----------------------------------------------------------------
    sqf_fifo_if #(.W(CMD_W), .DEPTH(FIFO_DEPTH)) tx_if ();
    sqf_fifo_if #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) rx_if ();

    sqf_fifo #(.W(CMD_W), .DEPTH(FIFO_DEPTH), .BASE(TX_FIFO_BASE)) u_tx_fifo (
        .clock(clock),
        .srst(srst),
        .port(tx_if.owner),
        .first_addr(tx_first_addr),
        .last_addr(tx_last_addr)
    );

    sqf_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH), .BASE(RX_FIFO_BASE)) u_rx_fifo (
        .clock(clock),
        .srst(srst),
        .port(rx_if.owner),
        .first_addr(rx_first_addr),
        .last_addr(rx_last_addr)
    );

    // ----------------------------------------------------------------
    // Frame control
    // ----------------------------------------------------------------
    sqf_state_t state;
    sqf_state_t next_state;
    logic [DATA_W-1:0] tx_sh;
    logic [DATA_W-1:0] rx_sh;
    logic eoq_cur;
    logic [BW-1:0] bit_cnt;
    logic sck_q;
    logic pcs_q;
    logic t_done;

    // A halted or end-of-queue-stopped device starts no new frame; a frame
    // already on the link is finished, except a slave frame that chip select
    // ends early, so the partner never sees a truncated word.
    wire go = ~halt & ~end_of_queue_flag;
    wire in_idle = state == ST_IDLE;
    wire in_shift = state == ST_SHIFT;
    wire m_start = in_idle & go & master_select_bit & ~tx_if.empty;
    wire s_start = in_idle & go & ~master_select_bit & ~pcs_s2;
    wire start = m_start | s_start;
    wire load_entry = start & ~tx_if.empty;
    wire clear_count_bit_exec = load_entry & tx_if.head[CLEAR_COUNT_BIT_POS];
    wire rise_evt = in_shift & (master_select_bit ? t_done & ~sck_q : sck_rise);
    wire fall_evt = in_shift & (master_select_bit ? t_done & sck_q : sck_fall);
    // The master samples on its own falling edge, because the returned bit
    // reaches the core two cycles late and a two-cycle half period cannot
    // cover that at the rising edge. A one-cycle half period is too short.
    wire rx_take = master_select_bit ? fall_evt : rise_evt;
    wire [DATA_W-1:0] rx_next = {rx_sh[DATA_W-2:0], sin_s2};
    wire last_bit = bit_cnt == BW'(FRAME_BITS - 1);
    wire frame_end = fall_evt & last_bit;
    wire slave_abort = in_shift & ~master_select_bit & pcs_s2;
    wire eoq_set = frame_end & eoq_cur;
    // Set wins over a clear arriving in the same cycle.
    wire next_eoq = eoq_set | (end_of_queue_flag & ~end_of_queue_flag_clear);

    // ----------------------------------------------------------------
    // Clock and delay scaling
    // ----------------------------------------------------------------
    wire [TIME_W-1:0] baud_pre = sqf_prescale(baud_prescaler, 1'b0);
    wire [TIME_W-1:0] baud_scl = sqf_scale(baud_scaler, 1'b0);
    wire [TIME_W-1:0] dly_pre = sqf_prescale(delay_prescaler, 1'b1);
    wire [TIME_W-1:0] dly_scl = sqf_scale(delay_scaler, 1'b1);
    wire [TIME_W-1:0] baud_period = TIME_W'(baud_pre * baud_scl) >> double_rate_bit;
    wire [TIME_W-1:0] half_raw = baud_period >> 1;
    wire [TIME_W-1:0] half_len = (half_raw == '0) ? TIME_ONE : half_raw;
    wire [TIME_W-1:0] delay_len = TIME_W'(dly_pre * dly_scl);
    wire t_load = m_start | (state == ST_LEAD & t_done) | (in_shift & master_select_bit & t_done);
    wire [TIME_W-1:0] t_len = (m_start | frame_end) ? delay_len : half_len;

    sqf_timer #(.W(TIME_W)) u_timer (
        .clock(clock),
        .srst(srst),
        .load(t_load),
        .length(t_len),
        .done(t_done),
        .busy()
    );

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (m_start) begin
                    next_state = ST_LEAD;
                end else if (s_start) begin
                    next_state = ST_SHIFT;
                end
            end
            ST_LEAD: begin
                if (t_done) begin
                    next_state = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (frame_end) begin
                    next_state = master_select_bit ? ST_TRAIL : ST_IDLE;
                end else if (slave_abort) begin
                    next_state = ST_IDLE;
                end
            end
            ST_TRAIL: begin
                if (t_done) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state <= ST_IDLE;
            tx_sh <= '0;
            rx_sh <= '0;
            eoq_cur <= 1'b0;
            bit_cnt <= '0;
            sck_q <= 1'b0;
            pcs_q <= 1'b1;
        end else begin
            state <= next_state;
            pcs_q <= ~(master_select_bit & (next_state != ST_IDLE));
            if (start) begin
                tx_sh <= load_entry ? tx_if.head[DATA_W-1:0] : '0;
                rx_sh <= '0;
                eoq_cur <= load_entry & tx_if.head[EOQ_POS];
                bit_cnt <= '0;
            end
            if (rx_take) begin
                rx_sh <= rx_next;
            end
            if (rise_evt) begin
                sck_q <= master_select_bit;
            end
            if (fall_evt) begin
                tx_sh <= {tx_sh[DATA_W-2:0], 1'b0};
                bit_cnt <= bit_cnt + 1'b1;
                sck_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Status, counter and receive pop
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            end_of_queue_flag <= 1'b0;
            end_of_queue_request <= 1'b0;
            running_status_bit <= 1'b0;
            transfer_counter_field <= '0;
            receive_pop_register <= '0;
        end else begin
            end_of_queue_flag <= next_eoq;
            end_of_queue_request <= next_eoq & end_of_queue_request_enable;
            running_status_bit <= ~halt & ~next_eoq;
            if (tcnt_write) begin
                transfer_counter_field <= tcnt_wdata;
            end else if (clear_count_bit_exec) begin
                transfer_counter_field <= '0;
            end else if (frame_end) begin
                transfer_counter_field <= transfer_counter_field + 1'b1;
            end
            if (rx_pop & ~rx_if.empty) begin
                receive_pop_register <= rx_if.head;
            end
        end
    end

    // The transmit FIFO keeps filling while stopped; only full or a transmit flush in the same cycle refuses.
    assign tx_if.push = tx_push_valid;
    assign tx_if.push_data = tx_push_data;
    assign tx_if.pop = load_entry;
    assign tx_if.flush = transmit_flush_bit;
    assign tx_push_ready = ~tx_if.full;
    // A frame arriving with the receive FIFO full is dropped.
    assign rx_if.push = frame_end;
    assign rx_if.push_data = master_select_bit ? rx_next : rx_sh;
    assign rx_if.pop = rx_pop;
    assign rx_if.flush = receive_flush_bit;
    assign receive_drain_flag = ~rx_if.empty;
    assign transmit_next_pointer = tx_if.ptr;
    assign transmit_entry_counter = tx_if.count;
    assign receive_pop_next_pointer = rx_if.ptr;
    assign receive_entry_counter = rx_if.count;
    assign sck_out = sck_q;
    assign sck_oe = master_select_bit;
    assign pcs_n_out = pcs_q;
    assign pcs_n_oe = master_select_bit;
    assign sout = tx_sh[FRAME_BITS-1];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_EOQ_SET: assert property (@(posedge clock) disable iff (srst)
        frame_end && eoq_cur |=> end_of_queue_flag && !running_status_bit)
        else $error("end-of-queue frame did not set the flag");
    AST_EOQ_STOP: assert property (@(posedge clock) disable iff (srst)
        end_of_queue_flag |-> !start ##1 (in_idle || $past(!in_idle)))
        else $error("frame started while stopped");
    AST_EOQ_RESUME: assert property (@(posedge clock) disable iff (srst)
        end_of_queue_flag && end_of_queue_flag_clear && !eoq_set && !halt
        |=> !end_of_queue_flag && running_status_bit)
        else $error("clearing the flag did not resume");
    AST_PUSH_STOPPED: assert property (@(posedge clock) disable iff (srst)
        end_of_queue_flag && tx_push_valid && !tx_if.full && !transmit_flush_bit
        |=> transmit_entry_counter == $past(transmit_entry_counter) + 1'b1)
        else $error("write refused while stopped");
    AST_TX_FLUSH: assert property (@(posedge clock) disable iff (srst)
        transmit_flush_bit |=> transmit_entry_counter == '0)
        else $error("transmit flush left entries");
    AST_RX_FLUSH: assert property (@(posedge clock) disable iff (srst)
        receive_flush_bit |=> receive_entry_counter == '0)
        else $error("receive flush left entries");
    AST_TCNT: assert property (@(posedge clock) disable iff (srst)
        tcnt_write |=> transfer_counter_field == $past(tcnt_wdata))
        else $error("counter write not taken");
    AST_HALT: assert property (@(posedge clock) disable iff (srst)
        halt && in_idle |=> in_idle)
        else $error("frame started while halted");
    AST_REQ: assert property (@(posedge clock) disable iff (srst)
        end_of_queue_request |-> end_of_queue_flag && $past(end_of_queue_request_enable))
        else $error("request without enable or flag");
endmodule

/* File: sim/sqf_slave_model.sv */
`timescale 1ns/1ps
module sqf_slave_model (
    input wire logic sck,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso,
    output logic [15:0] got,
    output int period,
    output int lead
);
    // -------------------------------------------------------------
    // Slave chip: listens only while cs_n is low, replies with a fixed byte.
    // -------------------------------------------------------------
    localparam logic [7:0] REPLY = 8'h96;
    logic [7:0] rx_sr;
    logic [7:0] tx_sr;
    int bits;
    time t_cs;
    time t_rise;
    initial begin
        miso = 1'b0;
        got = '0;
        period = 0;
        lead = 0;
        t_rise = 0;
    end
    // The model needs no enabling, so it is ready before the master.
    always @(negedge cs_n) begin
        tx_sr = REPLY;
        miso = REPLY[7];
        bits = 0;
        lead = -1;
        t_cs = $time;
    end
    always @(posedge sck) if (!cs_n) begin
        rx_sr = {rx_sr[6:0], mosi};
        period = int'(($time - t_rise) / 4);
        if (lead < 0) lead = int'(($time - t_cs) / 4);
        t_rise = $time;
        bits++;
        if (bits == 8) got = {got[7:0], rx_sr};
    end
    always @(negedge sck) if (!cs_n) begin
        tx_sr = tx_sr << 1;
        miso = tx_sr[7];
    end
    // A released data line must not keep its last level.
    always @(posedge cs_n) miso = ~miso;
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import sqf_pkg::*;
    logic clock, srst, halt, master_select_bit, transmit_flush_bit, receive_flush_bit;
    logic end_of_queue_flag_clear, end_of_queue_request_enable, double_rate_bit, tcnt_write;
    logic [1:0] baud_prescaler, delay_prescaler, transmit_next_pointer, receive_pop_next_pointer;
    logic [3:0] baud_scaler, delay_scaler;
    logic [15:0] tcnt_wdata, receive_pop_register, transfer_counter_field, got;
    logic tx_push_valid, tx_push_ready, rx_pop, end_of_queue_flag, end_of_queue_request;
    logic [31:0] tx_push_data, tx_first_addr, tx_last_addr, rx_first_addr, rx_last_addr;
    logic running_status_bit, receive_drain_flag, sck_out, sck_oe, pcs_n_out, pcs_n_oe;
    logic sout, miso;
    logic [2:0] transmit_entry_counter, receive_entry_counter;
    wire sck_w, pcs_w;
    int period, lead, bad_count, checks_done, i;
    assign sck_w = sck_oe ? sck_out : 1'b0;
    assign pcs_w = pcs_n_oe ? pcs_n_out : 1'b1;
    sqf_top dut_u (.clock(clock), .srst(srst), .halt(halt), .master_select_bit(master_select_bit),
        .transmit_flush_bit(transmit_flush_bit), .receive_flush_bit(receive_flush_bit),
        .end_of_queue_flag_clear(end_of_queue_flag_clear), .double_rate_bit(double_rate_bit),
        .end_of_queue_request_enable(end_of_queue_request_enable),
        .baud_prescaler(baud_prescaler), .baud_scaler(baud_scaler),
        .delay_prescaler(delay_prescaler), .delay_scaler(delay_scaler),
        .tcnt_write(tcnt_write), .tcnt_wdata(tcnt_wdata), .tx_push_valid(tx_push_valid),
        .tx_push_data(tx_push_data), .tx_push_ready(tx_push_ready), .rx_pop(rx_pop),
        .receive_pop_register(receive_pop_register), .end_of_queue_flag(end_of_queue_flag),
        .end_of_queue_request(end_of_queue_request), .running_status_bit(running_status_bit),
        .receive_drain_flag(receive_drain_flag), .transmit_next_pointer(transmit_next_pointer),
        .transmit_entry_counter(transmit_entry_counter), .rx_first_addr(rx_first_addr),
        .receive_pop_next_pointer(receive_pop_next_pointer), .rx_last_addr(rx_last_addr),
        .receive_entry_counter(receive_entry_counter), .tx_first_addr(tx_first_addr),
        .tx_last_addr(tx_last_addr), .transfer_counter_field(transfer_counter_field),
        .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe), .pcs_n_in(pcs_w),
        .pcs_n_out(pcs_n_out), .pcs_n_oe(pcs_n_oe), .sin(miso), .sout(sout));
    sqf_slave_model peer_u (.sck(sck_w), .cs_n(pcs_w), .mosi(sout), .miso(miso), .got(got),
        .period(period), .lead(lead));
    always #2 clock = ~clock;
    // -------------------------------------------------------------
    // Access tasks.
    // -------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic close_out;
        if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic push(input logic [31:0] w);
        @(negedge clock);
        tx_push_valid = 1'b1;
        tx_push_data = w;
        while (tx_push_ready !== 1'b1) @(negedge clock);
        @(negedge clock);
        tx_push_valid = 1'b0;
    endtask
    task automatic pop_chk(input logic [1:0] ptr_exp);
        @(negedge clock) rx_pop = 1'b1;
        @(negedge clock) rx_pop = 1'b0;
        chk("rx data", 32'h0000_0096, {16'h0000, receive_pop_register});
        chk("rx pointer", {30'h0000_0000, ptr_exp}, receive_pop_next_pointer);
    endtask
    task automatic wait_flag;
        for (i = 0; i < 600 && end_of_queue_flag !== 1'b1; i++) @(negedge clock);
    endtask
    // -------------------------------------------------------------
    // Tests.
    // -------------------------------------------------------------
    initial begin
        clock = 1'b0;
        srst = 1'b1;
        halt = 1'b1;
        master_select_bit = 1'b1;
        {transmit_flush_bit, receive_flush_bit, end_of_queue_flag_clear, rx_pop} = '0;
        {end_of_queue_request_enable, double_rate_bit, tcnt_write, tx_push_valid} = '0;
        {baud_prescaler, delay_prescaler, baud_scaler, delay_scaler} = '0;
        tcnt_wdata = '0;
        tx_push_data = '0;
        bad_count = 0;
        checks_done = 0;
        repeat (5) @(negedge clock);
        srst = 1'b0;
        @(negedge clock);
        chk("flag", 0, end_of_queue_flag);
        chk("running", 0, running_status_bit);
        for (int k = 0; k < 4; k++) push(32'h0000_0011);
        repeat (20) @(negedge clock);
        chk("tx count", 4, transmit_entry_counter);
        chk("tx ready", 0, tx_push_ready);
        chk("tx first", TX_FIFO_BASE, tx_first_addr);
        chk("tx last", TX_FIFO_BASE + 32'h0000_000C, tx_last_addr);
        @(negedge clock) transmit_flush_bit = 1'b1;
        @(negedge clock) transmit_flush_bit = 1'b0;
        chk("tx flushed", 0, transmit_entry_counter);
        chk("tx ptr", 0, transmit_next_pointer);
        tcnt_wdata = 16'h1234;
        @(negedge clock) tcnt_write = 1'b1;
        @(negedge clock) tcnt_write = 1'b0;
        chk("tcnt", 32'h0000_1234, transfer_counter_field);
        push(32'h0000_00A5);
        push(32'h0800_003C);
        chk("tx last", TX_FIFO_BASE + 32'h0000_0004, tx_last_addr);
        end_of_queue_request_enable = 1'b1;
        halt = 1'b0;
        wait_flag;
        repeat (2) @(negedge clock);
        chk("flag", 1, end_of_queue_flag);
        chk("running", 0, running_status_bit);
        chk("frames", 32'h0000_A53C, got);
        chk("request", 1, end_of_queue_request);
        chk("tcnt", 32'h0000_1236, transfer_counter_field);
        chk("rx count", 2, receive_entry_counter);
        chk("rx first", RX_FIFO_BASE, rx_first_addr);
        chk("rx last", RX_FIFO_BASE + 32'h0000_0004, rx_last_addr);
        chk("period", 4, period);
        chk("tx ptr", 2, transmit_next_pointer);
        baud_prescaler = 2'h1;
        delay_prescaler = 2'h1;
        push(32'h0400_00C3);
        push(32'h0800_0081);
        repeat (100) @(negedge clock);
        chk("tx held", 2, transmit_entry_counter);
        pop_chk(2'h1);
        pop_chk(2'h2);
        chk("drain", 0, receive_drain_flag);
        end_of_queue_request_enable = 1'b0;
        @(negedge clock) end_of_queue_flag_clear = 1'b1;
        @(negedge clock) end_of_queue_flag_clear = 1'b0;
        wait_flag;
        repeat (2) @(negedge clock);
        chk("frames", 32'h0000_C381, got);
        chk("tcnt", 2, transfer_counter_field);
        chk("request", 0, end_of_queue_request);
        chk("period", 6, period);
        chk("lead", 1, lead >= 6);
        chk("tx ptr", 0, transmit_next_pointer);
        pop_chk(2'h3);
        @(negedge clock) receive_flush_bit = 1'b1;
        @(negedge clock) receive_flush_bit = 1'b0;
        chk("rx count", 0, receive_entry_counter);
        chk("rx ptr", 0, receive_pop_next_pointer);
        halt = 1'b1;
        @(negedge clock) {transmit_flush_bit, receive_flush_bit} = 2'b11;
        @(negedge clock) {transmit_flush_bit, receive_flush_bit} = 2'b00;
        master_select_bit = 1'b0;
        @(negedge clock) halt = 1'b0;
        repeat (4) @(negedge clock);
        chk("sck oe", 0, sck_oe);
        chk("pcs oe", 0, pcs_n_oe);
        close_out;
    end
    initial begin
        repeat (3000) @(posedge clock);
        bad_count++;
        close_out;
    end
endmodule
